// ---- otpg_consts.svh ----
// Offsets, field positions, reset values and pattern codes of the output test pattern generator
`ifndef OTPG_CONSTS_SVH
`define OTPG_CONSTS_SVH
`define OTPG_OFF_CUST_A_LO 8'h33
`define OTPG_OFF_CUST_A_HI 8'h34
`define OTPG_OFF_CUST_B_LO 8'h35
`define OTPG_OFF_CUST_B_HI 8'h36
`define OTPG_OFF_SEL1 8'h37
`define OTPG_OFF_SEL2 8'h38
`define OTPG_OFF_SHARE 8'h39
`define OTPG_OFF_RESTART 8'h3A
`define OTPG_OFF_STATUS 8'h3C
`define OTPG_REG_RESET 8'h00
`define OTPG_SEL_Q_MSB 7
`define OTPG_SEL_Q_LSB 4
`define OTPG_SEL_I_MSB 3
`define OTPG_SEL_I_LSB 0
`define OTPG_SHARE_BIT 0
`define OTPG_RST_EN_BIT 0
`define OTPG_RST_PULSE_BIT 1
`define OTPG_CODE_NORMAL 4'h0
`define OTPG_CODE_ZEROS 4'h1
`define OTPG_CODE_ONES 4'h2
`define OTPG_CODE_TOGGLE 4'h3
`define OTPG_CODE_RAMP 4'h4
`define OTPG_CODE_SINGLE 4'h6
`define OTPG_CODE_DOUBLE 4'h7
`define OTPG_CODE_DESKEW 4'h8
`define OTPG_TOGGLE_WORD 16'hAAAA
`define OTPG_DESKEW_WORD 16'h0FFF
`endif

// ---- otpg_lane.sv ----
// One stream lane: picks normal data or a test pattern
`timescale 1ns/1ps
`default_nettype none
`include "otpg_consts.svh"
module otpg_lane (
	otpg_lane_if.dst ctx,
	input wire logic [15:0] norm_i,
	output logic [15:0] word_o
);
	import otpg_pkg::*;
	always_comb begin
		case (ctx.code)
			`OTPG_CODE_ZEROS: word_o = 16'h0000;
			`OTPG_CODE_ONES: word_o = 16'hFFFF;
			`OTPG_CODE_TOGGLE: word_o = ctx.phase ? ~`OTPG_TOGGLE_WORD : `OTPG_TOGGLE_WORD;
			`OTPG_CODE_RAMP: word_o = ctx.ramp;
			`OTPG_CODE_SINGLE: word_o = ctx.word_a;
			`OTPG_CODE_DOUBLE: word_o = ctx.phase ? ctx.word_b : ctx.word_a;
			`OTPG_CODE_DESKEW: word_o = `OTPG_DESKEW_WORD;
			default: word_o = norm_i;
		endcase
	end
endmodule // otpg_lane
`default_nettype wire

// ---- otpg_lane_if.sv ----
// Pattern context carried from the top to each lane
`timescale 1ns/1ps
`default_nettype none
interface otpg_lane_if;
	logic [3:0] code;
	logic [15:0] word_a;
	logic [15:0] word_b;
	logic [15:0] ramp;
	logic phase;
	modport src (output code, output word_a, output word_b, output ramp, output phase);
	modport dst (input code, input word_a, input word_b, input ramp, input phase);
endinterface
`default_nettype wire

// ---- otpg_link_sink.sv ----
// Link-side sink: takes words promptly, every other cycle, or not at all
`timescale 1ns/1ps
`default_nettype none
module otpg_link_sink (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [1:0] mode_i,
	input wire logic valid_i,
	input wire logic [63:0] data_i,
	output logic ready_o
);
	logic [63:0] got [$];
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			ready_o <= 1'b0;
		end else begin
			// Mode 2 stops the link so the buffer must hold words
			ready_o <= mode_i == 2'h0 || (mode_i == 2'h1 && !ready_o);
			if (valid_i && ready_o)
				got.push_back(data_i);
		end
	end
endmodule // otpg_link_sink
`default_nettype wire

// ---- otpg_pkg.sv ----
// Types shared by the output test pattern generator
`default_nettype none
package otpg_pkg;
	typedef logic [15:0] otpg_word_t;
	typedef logic [3:0] otpg_code_t;
	typedef enum logic [1:0] {
		OTPG_BUS_IDLE = 2'b00,
		OTPG_BUS_WRITE = 2'b01,
		OTPG_BUS_READ = 2'b11
	} otpg_bus_e;
endpackage
`default_nettype wire

// ---- otpg_skid.sv ----
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module otpg_skid (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [63:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [63:0] out_data_o
);
	typedef struct packed {
		logic [63:0] d0;
		logic [63:0] d1;
		logic [1:0] cnt;
	} otpg_skid_s;
	otpg_skid_s st_r;
	otpg_skid_s st_nxt;
	logic push;
	logic pop;
	assign in_ready_o = (st_r.cnt != 2'h2);
	assign out_valid_o = (st_r.cnt != 2'h0);
	assign out_data_o = st_r.d0;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	always_comb begin
		st_nxt = st_r;
		if (pop) begin
			st_nxt.d0 = st_r.d1;
		end
		if (push) begin
			if ((st_r.cnt == 2'h0) || ((st_r.cnt == 2'h1) && pop)) begin
				st_nxt.d0 = in_data_i;
			end else begin
				st_nxt.d1 = in_data_i;
			end
		end
		st_nxt.cnt = 2'(st_r.cnt + {1'b0, push} - {1'b0, pop});
	end
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule // otpg_skid
`default_nettype wire

// ---- otpg_top.sv ----
// Output test pattern generator for two down-converter I/Q streams
`timescale 1ns/1ps
`default_nettype none
`include "otpg_consts.svh"
module otpg_top (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hsel,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic samp_valid_i,
	output logic samp_ready_o,
	input wire logic [15:0] first_down_converter_i_i,
	input wire logic [15:0] first_down_converter_q_i,
	input wire logic [15:0] second_down_converter_i_i,
	input wire logic [15:0] second_down_converter_q_i,
	output logic link_valid_o,
	input wire logic link_ready_i,
	output logic [15:0] first_down_converter_i_o,
	output logic [15:0] first_down_converter_q_o,
	output logic [15:0] second_down_converter_i_o,
	output logic [15:0] second_down_converter_q_o,
	output logic pattern_active_o
);
	import otpg_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0] sel1;
		logic [7:0] sel2;
		logic share;
		logic restart_enable;
		logic restart_pulse;
		logic [15:0] custom_word_a;
		logic [15:0] custom_word_b;
		logic [15:0] ramp;
		logic phase;
		logic [7:0] wr_addr;
		otpg_bus_e bus;
		logic [31:0] rdata;
		logic [7:0] restart_count;
	} otpg_top_s;
	otpg_top_s st_r;
	otpg_top_s st_nxt;

	logic addr_ok;
	logic restart_fire;
	logic [7:0] rd_val;
	logic [3:0] code_fi;
	logic [3:0] code_fq;
	logic [3:0] code_si;
	logic [3:0] code_sq;
	logic [63:0] lane_words;
	logic [63:0] buf_out;
	logic buf_in_ready;

	// ==========================================================
	// Stream selection
	// Sharing off: all four streams follow one code
	always_comb begin
		if (st_r.share) begin
			code_fi = st_r.sel1[`OTPG_SEL_I_MSB:`OTPG_SEL_I_LSB];
			code_fq = st_r.sel1[`OTPG_SEL_Q_MSB:`OTPG_SEL_Q_LSB];
			code_si = st_r.sel2[`OTPG_SEL_I_MSB:`OTPG_SEL_I_LSB];
			code_sq = st_r.sel2[`OTPG_SEL_Q_MSB:`OTPG_SEL_Q_LSB];
		end else begin
			code_fi = st_r.sel1[`OTPG_SEL_I_MSB:`OTPG_SEL_I_LSB];
			code_fq = code_fi;
			code_si = code_fi;
			code_sq = code_fi;
		end
	end

	otpg_lane_if ctx_fi ();
	otpg_lane_if ctx_fq ();
	otpg_lane_if ctx_si ();
	otpg_lane_if ctx_sq ();
	assign ctx_fi.code = code_fi;
	assign ctx_fq.code = code_fq;
	assign ctx_si.code = code_si;
	assign ctx_sq.code = code_sq;
	assign ctx_fi.word_a = st_r.custom_word_a;
	assign ctx_fq.word_a = st_r.custom_word_a;
	assign ctx_si.word_a = st_r.custom_word_a;
	assign ctx_sq.word_a = st_r.custom_word_a;
	assign ctx_fi.word_b = st_r.custom_word_b;
	assign ctx_fq.word_b = st_r.custom_word_b;
	assign ctx_si.word_b = st_r.custom_word_b;
	assign ctx_sq.word_b = st_r.custom_word_b;
	assign ctx_fi.ramp = st_r.ramp;
	assign ctx_fq.ramp = st_r.ramp;
	assign ctx_si.ramp = st_r.ramp;
	assign ctx_sq.ramp = st_r.ramp;
	assign ctx_fi.phase = st_r.phase;
	assign ctx_fq.phase = st_r.phase;
	assign ctx_si.phase = st_r.phase;
	assign ctx_sq.phase = st_r.phase;

	otpg_lane u_lane_fi (.ctx(ctx_fi), .norm_i(first_down_converter_i_i), .word_o(lane_words[15:0]));
	otpg_lane u_lane_fq (.ctx(ctx_fq), .norm_i(first_down_converter_q_i), .word_o(lane_words[31:16]));
	otpg_lane u_lane_si (.ctx(ctx_si), .norm_i(second_down_converter_i_i), .word_o(lane_words[47:32]));
	otpg_lane u_lane_sq (.ctx(ctx_sq), .norm_i(second_down_converter_q_i), .word_o(lane_words[63:48]));

	// ==========================================================
	// Output buffer
	// A stall by the link holds the source rather than dropping words
	otpg_skid u_skid (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.in_valid_i(samp_valid_i),
		.in_ready_o(buf_in_ready),
		.in_data_i(lane_words),
		.out_valid_o(link_valid_o),
		.out_ready_i(link_ready_i),
		.out_data_o(buf_out)
	);
	assign samp_ready_o = buf_in_ready;
	assign first_down_converter_i_o = buf_out[15:0];
	assign first_down_converter_q_o = buf_out[31:16];
	assign second_down_converter_i_o = buf_out[47:32];
	assign second_down_converter_q_o = buf_out[63:48];
	assign pattern_active_o = (code_fi != `OTPG_CODE_NORMAL) || (code_fq != `OTPG_CODE_NORMAL)
		|| (code_si != `OTPG_CODE_NORMAL) || (code_sq != `OTPG_CODE_NORMAL);

	// ==========================================================
	// Bus slave
	assign addr_ok = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_r.rdata;

	always_comb begin
		case (haddr[9:2])
			`OTPG_OFF_CUST_A_LO: rd_val = st_r.custom_word_a[7:0];
			`OTPG_OFF_CUST_A_HI: rd_val = st_r.custom_word_a[15:8];
			`OTPG_OFF_CUST_B_LO: rd_val = st_r.custom_word_b[7:0];
			`OTPG_OFF_CUST_B_HI: rd_val = st_r.custom_word_b[15:8];
			`OTPG_OFF_SEL1: rd_val = st_r.sel1;
			`OTPG_OFF_SEL2: rd_val = st_r.sel2;
			`OTPG_OFF_SHARE: rd_val = {7'h00, st_r.share};
			`OTPG_OFF_RESTART: rd_val = {6'h00, st_r.restart_pulse, st_r.restart_enable};
			`OTPG_OFF_STATUS: rd_val = st_r.restart_count;
			default: rd_val = 8'h00;
		endcase
	end

	// Falling edge of the restart bit while enabled
	assign restart_fire = (st_r.bus == OTPG_BUS_WRITE) && (st_r.wr_addr == `OTPG_OFF_RESTART)
		&& st_r.restart_enable && st_r.restart_pulse && !hwdata[`OTPG_RST_PULSE_BIT];

	// ==========================================================
	// Next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.bus = OTPG_BUS_IDLE;
		if (addr_ok) begin
			st_nxt.bus = hwrite ? OTPG_BUS_WRITE : OTPG_BUS_READ;
			st_nxt.wr_addr = haddr[9:2];
			if (!hwrite) begin
				st_nxt.rdata = {24'h000000, rd_val};
			end
		end
		if (st_r.bus == OTPG_BUS_WRITE) begin
			case (st_r.wr_addr)
				`OTPG_OFF_CUST_A_LO: st_nxt.custom_word_a[7:0] = hwdata[7:0];
				`OTPG_OFF_CUST_A_HI: st_nxt.custom_word_a[15:8] = hwdata[7:0];
				`OTPG_OFF_CUST_B_LO: st_nxt.custom_word_b[7:0] = hwdata[7:0];
				`OTPG_OFF_CUST_B_HI: st_nxt.custom_word_b[15:8] = hwdata[7:0];
				`OTPG_OFF_SEL1: st_nxt.sel1 = hwdata[7:0];
				`OTPG_OFF_SEL2: st_nxt.sel2 = hwdata[7:0];
				`OTPG_OFF_SHARE: st_nxt.share = hwdata[`OTPG_SHARE_BIT];
				`OTPG_OFF_RESTART: begin
					st_nxt.restart_enable = hwdata[`OTPG_RST_EN_BIT];
					st_nxt.restart_pulse = hwdata[`OTPG_RST_PULSE_BIT];
				end
				default: st_nxt.rdata = st_r.rdata;
			endcase
		end
		// Pattern advances only on accepted samples, so a stall keeps the sequence intact
		if (restart_fire) begin
			st_nxt.ramp = 16'h0000;
			st_nxt.phase = 1'b0;
			st_nxt.restart_count = 8'(st_r.restart_count + 8'h01);
		end else if (samp_valid_i && buf_in_ready) begin
			st_nxt.ramp = 16'(st_r.ramp + 16'h0001);
			st_nxt.phase = !st_r.phase;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule // otpg_top
`default_nettype wire

// ---- otpg_top_asserts.sv ----
// Port checker for the output test pattern generator
`timescale 1ns/1ps
`default_nettype none
module otpg_top_asserts (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic samp_valid_i,
	input wire logic samp_ready_o,
	input wire logic [15:0] first_down_converter_i_i,
	input wire logic link_valid_o,
	input wire logic link_ready_i,
	input wire logic [15:0] first_down_converter_i_o,
	input wire logic [15:0] second_down_converter_q_o,
	input wire logic pattern_active_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	a_reset_quiet: assert property ($fell(reset_i) |-> !link_valid_o && samp_ready_o && !pattern_active_o)
		else $error("state not cleared by reset");
	a_word_holds: assert property (link_valid_o && !link_ready_i |=> link_valid_o
		&& $stable(first_down_converter_i_o) && $stable(second_down_converter_q_o)) else $error("word lost in stall");
	a_normal_pass: assert property (samp_valid_i && samp_ready_o && !link_valid_o && !pattern_active_o
		|=> first_down_converter_i_o == $past(first_down_converter_i_i)) else $error("normal data changed");
	a_accept_shows: assert property (samp_valid_i && samp_ready_o |=> link_valid_o)
		else $error("accepted word not offered");
	a_empty_takes: assert property (!link_valid_o |-> samp_ready_o) else $error("empty buffer refuses");
	a_full_valid: assert property (!samp_ready_o |-> link_valid_o) else $error("refusal without word");
	a_full_drains: assert property (!samp_ready_o && link_ready_i |=> samp_ready_o)
		else $error("drain frees no room");
	a_bus_okay: assert property (hreadyout && !hresp) else $error("bus wait or error");
	a_upper_zero: assert property (hrdata[31:8] == 24'h000000) else $error("upper read bits set");
endmodule // otpg_top_asserts
bind otpg_top otpg_top_asserts u_chk (.sys_clk_i, .reset_i, .hrdata, .hreadyout, .hresp, .samp_valid_i,
	.samp_ready_o, .first_down_converter_i_i, .link_valid_o, .link_ready_i, .first_down_converter_i_o,
	.second_down_converter_q_o, .pattern_active_o);
`default_nettype wire

// ---- test_ddc_output_test_pattern_gen.sv ----
// Self-checking bench for the output test pattern generator
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module test_ddc_output_test_pattern_gen;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0, mode = 2'h0;
	logic hwrite = 1'b0, hreadyout, hresp, samp_valid_i = 1'b0, samp_ready_o, link_valid_o, link_ready, ok, act;
	logic [15:0] din [4] = '{default: 16'h0000};
	logic [15:0] dout [4];
	logic [15:0] ca = 16'h0000, cb = 16'h0000;
	logic [7:0] s1, s2;
	logic share;
	logic [63:0] e, g, exp_q [$];
	logic [3:0] codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hF};
	int n = 0, fail_count = 0, checks_done = 0, cyc = 0;
	otpg_top u_dut (.sys_clk_i, .reset_i, .haddr, .htrans, .hwrite, .hsize(3'h2), .hsel(1'b1), .hready(hreadyout),
		.hwdata, .hrdata, .hreadyout, .hresp, .samp_valid_i, .samp_ready_o, .first_down_converter_i_i(din[0]),
		.first_down_converter_q_i(din[1]), .second_down_converter_i_i(din[2]), .second_down_converter_q_i(din[3]),
		.link_valid_o, .link_ready_i(link_ready), .first_down_converter_i_o(dout[0]),
		.first_down_converter_q_o(dout[1]), .second_down_converter_i_o(dout[2]),
		.second_down_converter_q_o(dout[3]), .pattern_active_o(act));
	otpg_link_sink u_sink (.sys_clk_i, .reset_i, .mode_i(mode), .valid_i(link_valid_o),
		.data_i({dout[3], dout[2], dout[1], dout[0]}), .ready_o(link_ready));
	always #2.5 sys_clk_i = ~sys_clk_i;
	// Cut a hang short well above the expected run length
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			conclude();
		end
	end
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		htrans <= 2'h2;
		haddr <= {22'h0, a, 2'h0};
		hwrite <= w;
		do begin @(negedge sys_clk_i); ok = hreadyout; @(posedge sys_clk_i); end while (ok !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(negedge sys_clk_i); ok = hreadyout; rd = hrdata; @(posedge sys_clk_i); end while (ok !== 1'b1);
	endtask
	function automatic logic [15:0] pat(input int j);
		logic [7:0] s;
		s = j < 2 ? s1 : s2;
		case (share ? (j[0] ? s[7:4] : s[3:0]) : s1[3:0])
			4'h1: return 16'h0000;
			4'h2: return 16'hFFFF;
			4'h3: return n[0] ? 16'h5555 : 16'hAAAA;
			4'h4: return n[15:0];
			4'h6: return ca;
			4'h7: return n[0] ? cb : ca;
			4'h8: return 16'h0FFF;
			default: return din[j];
		endcase
	endfunction
	task automatic go(input logic [7:0] a, input logic [7:0] b, input logic sh, input int cnt);
		mode <= 2'h2;
		s1 = a;
		s2 = b;
		share = sh;
		bus(1'b1, 8'h37, {24'h0, a});
		bus(1'b1, 8'h38, {24'h0, b});
		bus(1'b1, 8'h39, {31'h0, sh});
		samp_valid_i <= 1'b1;
		for (int k = 0; k < cnt; k++) begin
			for (int j = 0; j < 4; j++)
				din[j] <= {4'(j + 1), n[11:0]};
			if (k == 2) begin
				mode <= 2'h1;
				@(negedge sys_clk_i);
				`CHK("full refusal", 1'b0, samp_ready_o)
			end
			do begin
				@(negedge sys_clk_i);
				ok = samp_ready_o;
				if (k == 0) `CHK("active", (share ? (s1 != 8'h00 || s2 != 8'h00) : (s1[3:0] != 4'h0)), act)
				@(posedge sys_clk_i);
			end while (ok !== 1'b1);
			for (int j = 0; j < 4; j++)
				e[16 * j +: 16] = pat(j);
			exp_q.push_back(e);
			n++;
		end
		samp_valid_i <= 1'b0;
		for (int w = 0; w < 80 && u_sink.got.size() < exp_q.size(); w++)
			@(posedge sys_clk_i);
		while (exp_q.size() > 0) begin
			e = exp_q.pop_front();
			// Pop once so a mismatch report does not consume a second word
			g = u_sink.got.size() ? u_sink.got.pop_front() : 64'hx;
			`CHK("word", e, g)
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		bus(1'b0, 8'h33, 32'h0);
		`CHK("custom reset", 32'h0, rd)
		bus(1'b0, 8'h3A, 32'h0);
		`CHK("restart reset", 32'h0, rd)
		bus(1'b1, 8'h33, 32'h34);
		bus(1'b1, 8'h34, 32'h12);
		bus(1'b1, 8'h35, 32'hCD);
		bus(1'b1, 8'h36, 32'hAB);
		ca = 16'h1234;
		cb = 16'hABCD;
		bus(1'b0, 8'h36, 32'h0);
		`CHK("custom high", 32'hAB, rd)
		bus(1'b0, 8'h10, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		// Own fields hold other codes so a wrong share reading shows
		foreach (codes[i])
			go({4'h1, codes[i]}, 8'h22, 1'b0, 3);
		go(8'h83, 8'h67, 1'b1, 4);
		go(8'h46, 8'hF2, 1'b1, 4);
		// Pulse without enable must leave the ramp running
		bus(1'b1, 8'h3A, 32'h2);
		bus(1'b1, 8'h3A, 32'h0);
		// Odd sample total leaves the phase on its second word before the restart
		go(8'h44, 8'h44, 1'b1, 4);
		bus(1'b1, 8'h3A, 32'h1);
		bus(1'b0, 8'h3A, 32'h0);
		`CHK("enable bit", 32'h1, rd)
		bus(1'b1, 8'h3A, 32'h3);
		bus(1'b1, 8'h3A, 32'h1);
		n = 0;
		go(8'h73, 8'h43, 1'b1, 3);
		bus(1'b0, 8'h3C, 32'h0);
		`CHK("restart count", 32'h1, rd)
		conclude();
	end
endmodule // test_ddc_output_test_pattern_gen
`default_nettype wire
